// >>> common/oad_defines.svh
// Constants for the operand address decoder
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
`define OAD_PREBYTE 8'h9E
`define OAD_PZ_HI 8'h00
`define OAD_PC_RST 16'h0000
`define OAD_COL_RMW 4'h6
`define OAD_COL_IX 4'hA
`define OAD_COL_IX2 4'hB
`define OAD_COL_IX1 4'hC
`define OAD_COL_SP2 4'hD
`define OAD_COL_SP1 4'hE
`define OAD_COL_HX 4'hF
`define OAD_LO_COMPARE_BRANCH_EQUAL 4'h1
`define OAD_LO_GAP2 4'h2
`define OAD_LO_CPHX 4'h3
`define OAD_LO_GAP5 4'h5
`define OAD_LO_STA 4'h7
`define OAD_LO_ALU_MAX 4'hB
`define OAD_LO_DECREMENT_BRANCH_NONZERO 4'hB
`define OAD_LO_TST 4'hD
`define OAD_LO_LDHX 4'hE
`define OAD_LO_STX 4'hF
`define OAD_LEN_TWO 3'h2
`define OAD_LEN_THREE 3'h3
`define OAD_LEN_FOUR 3'h4
`define OAD_CYC_ILL 4'h1
`define OAD_CYC_RMW 4'h6
`define OAD_CYC_DECREMENT_BRANCH_NONZERO 4'h8
`define OAD_CYC_TST 4'h5
`define OAD_CYC_SP2 4'h5
`define OAD_CYC_SP1 4'h4
`define OAD_CYC_CPHX 4'h6
`define OAD_CYC_LDHX 4'h5
`define OAD_CYC_IX2 4'h6
`define OAD_CYC_IX1 4'h5
`endif

// >>> common/oad_pkg.sv
// Types for the operand address decoder
package oad_pkg;
	typedef enum logic [3:0] {
		no_operand_mode = 4'h0,
		pc_offset_mode = 4'h1,
		literal_operand_mode = 4'h2,
		page_zero_mode = 4'h3,
		full_address_mode = 4'h4,
		index_mode = 4'h5,
		index_byte_mode = 4'h6,
		index_word_mode = 4'h7,
		index_post_increment_mode = 4'h8,
		index_byte_post_increment_mode = 4'h9,
		stack_offset_byte_mode = 4'hA,
		stack_offset_word_mode = 4'hB
	} oad_mode_t;
	typedef enum logic [1:0] {
		dst_none = 2'h0,
		dst_page_zero = 2'h1,
		dst_post_increment = 2'h2
	} oad_dst_t;
	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_fetch = 7'h02,
		st_args = 7'h04,
		st_addr = 7'h08,
		st_opnd = 7'h10,
		st_issue = 7'h20,
		st_branch = 7'h40
	} oad_state_t;
endpackage : oad_pkg

// >>> logic/oad_offset_add.sv
// Base plus byte or word offset adder
`timescale 1ns/1ps
`default_nettype none
module oad_offset_add (
	// Operands
	input wire logic [15:0] base,
	input wire logic [7:0] off_hi,
	input wire logic [7:0] off_lo,
	// Offset form
	input wire logic word,
	input wire logic sext,
	// Result
	output logic [15:0] sum
);
	logic [15:0] offset;
	always_comb begin
		if (word)
			offset = {off_hi, off_lo};
		else if (sext)
			offset = {{8{off_lo[7]}}, off_lo};
		else
			offset = {8'h00, off_lo};
	end
	assign sum = 16'(base + offset);
endmodule : oad_offset_add
`default_nettype wire

// >>> logic/oad_decoder.sv
// Operand address decoder: fetch, mode decode, address and operand fetch
`timescale 1ns/1ps
`default_nettype none
`include "oad_defines.svh"
module oad_decoder (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Restart from the core
	input wire logic start,
	input wire logic [15:0] start_pc,
	// Core pointer registers
	input wire logic [15:0] sp_val,
	input wire logic [15:0] hx_val,
	// Primary opcode map lookup
	output logic [7:0] map_opcode,
	input wire oad_pkg::oad_mode_t map_mode,
	input wire oad_pkg::oad_dst_t map_dst,
	input wire logic map_branch,
	input wire logic map_wide,
	input wire logic map_store,
	input wire logic map_illegal,
	input wire logic [2:0] map_len,
	input wire logic [3:0] map_cycles,
	// Address space read port
	output logic mem_req,
	output logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Decoded instruction
	output logic dec_valid,
	input wire logic dec_ready,
	output logic dec_page2,
	output logic [7:0] dec_opcode,
	output oad_pkg::oad_mode_t dec_mode,
	output oad_pkg::oad_dst_t dec_dst,
	output logic [15:0] dec_ea,
	output logic [15:0] dec_dst_ea,
	output logic [15:0] dec_operand,
	output logic [2:0] dec_len,
	output logic [3:0] dec_cycles,
	output logic dec_branch,
	output logic dec_illegal,
	output logic idx_inc,
	// Branch resolution
	input wire logic br_cond_valid,
	input wire logic br_cond,
	output logic pc_valid,
	output logic [15:0] pc_out
);
	oad_pkg::oad_state_t state_reg, state_next;
	oad_pkg::oad_mode_t p_mode, c_mode;
	oad_pkg::oad_dst_t c_dst;
	logic [15:0] pc_reg, addr_reg, target_reg, ea_next, ea_sum, tgt_sum, lit_val;
	logic [7:0] opcode_reg;
	logic [7:0] arg_reg [0:2];
	logic [7:0] last_arg;
	logic [3:0] p_cyc, c_cyc, hi, lo;
	logic [2:0] p_len, c_len, args_need;
	logic [1:0] cnt_reg, last_idx;
	logic page2_reg, opnd_cnt_reg, wide_reg;
	logic p_br, p_wide, p_store, p_ill, c_br, c_wide, c_store, c_ill;
	logic is_prefix, c_is_sp, c_word, needs_read;

	// Second opcode table
	assign hi = opcode_reg[7:4];
	assign lo = opcode_reg[3:0];
	always_comb begin
		p_mode = oad_pkg::no_operand_mode;
		p_br = 1'b0;
		p_wide = 1'b0;
		p_store = 1'b0;
		p_ill = 1'b1;
		p_len = `OAD_LEN_TWO;
		p_cyc = `OAD_CYC_ILL;
		case (hi)
			`OAD_COL_RMW: begin
				if (lo != `OAD_LO_GAP2 && lo != `OAD_LO_GAP5 && lo != `OAD_LO_LDHX) begin
					p_ill = 1'b0;
					p_mode = oad_pkg::stack_offset_byte_mode;
					p_len = `OAD_LEN_THREE;
					p_cyc = `OAD_CYC_RMW;
					if (lo == `OAD_LO_COMPARE_BRANCH_EQUAL || lo == `OAD_LO_DECREMENT_BRANCH_NONZERO) begin
						p_len = `OAD_LEN_FOUR;
						p_br = 1'b1;
					end
					if (lo == `OAD_LO_DECREMENT_BRANCH_NONZERO)
						p_cyc = `OAD_CYC_DECREMENT_BRANCH_NONZERO;
					if (lo == `OAD_LO_TST)
						p_cyc = `OAD_CYC_TST;
				end
			end
			`OAD_COL_SP2, `OAD_COL_SP1: begin
				if (lo <= `OAD_LO_ALU_MAX || lo >= `OAD_LO_LDHX) begin
					p_ill = 1'b0;
					p_store = (lo == `OAD_LO_STA) || (lo == `OAD_LO_STX);
					if (hi == `OAD_COL_SP2) begin
						p_mode = oad_pkg::stack_offset_word_mode;
						p_len = `OAD_LEN_FOUR;
						p_cyc = `OAD_CYC_SP2;
					end else begin
						p_mode = oad_pkg::stack_offset_byte_mode;
						p_len = `OAD_LEN_THREE;
						p_cyc = `OAD_CYC_SP1;
					end
				end
			end
			`OAD_COL_HX: begin
				if (lo == `OAD_LO_CPHX || lo >= `OAD_LO_LDHX) begin
					p_ill = 1'b0;
					p_wide = 1'b1;
					p_store = (lo == `OAD_LO_STX);
					p_mode = oad_pkg::stack_offset_byte_mode;
					p_len = `OAD_LEN_THREE;
					p_cyc = (lo == `OAD_LO_CPHX) ? `OAD_CYC_CPHX : `OAD_CYC_LDHX;
				end
			end
			`OAD_COL_IX, `OAD_COL_IX2, `OAD_COL_IX1: begin
				if (lo == `OAD_LO_LDHX) begin
					p_ill = 1'b0;
					p_wide = 1'b1;
					if (hi == `OAD_COL_IX) begin
						p_mode = oad_pkg::index_mode;
						p_cyc = `OAD_CYC_LDHX;
					end else if (hi == `OAD_COL_IX2) begin
						p_mode = oad_pkg::index_word_mode;
						p_len = `OAD_LEN_FOUR;
						p_cyc = `OAD_CYC_IX2;
					end else begin
						p_mode = oad_pkg::index_byte_mode;
						p_len = `OAD_LEN_THREE;
						p_cyc = `OAD_CYC_IX1;
					end
				end
			end
			default: p_ill = 1'b1;
		endcase
	end

	// Table select by prefix
	assign c_mode = page2_reg ? p_mode : map_mode;
	assign c_dst = page2_reg ? oad_pkg::dst_none : map_dst;
	assign c_br = page2_reg ? p_br : map_branch;
	assign c_wide = page2_reg ? p_wide : map_wide;
	assign c_store = page2_reg ? p_store : map_store;
	assign c_ill = page2_reg ? p_ill : map_illegal;
	assign c_len = page2_reg ? p_len : map_len;
	assign c_cyc = page2_reg ? p_cyc : map_cycles;
	assign map_opcode = opcode_reg;
	assign args_need = 3'(c_len - 3'h1 - {2'h0, page2_reg});
	assign last_idx = 2'(args_need - 3'h1);
	// No argument bytes: keep the index inside the three stored bytes
	assign last_arg = (last_idx == 2'h3) ? 8'h00 : arg_reg[last_idx];

	// Effective address forming
	assign c_is_sp = (c_mode == oad_pkg::stack_offset_byte_mode)
		|| (c_mode == oad_pkg::stack_offset_word_mode);
	assign c_word = (c_mode == oad_pkg::stack_offset_word_mode)
		|| (c_mode == oad_pkg::index_word_mode);
	oad_offset_add u_ea_add (
		.base(c_is_sp ? sp_val : hx_val),
		.off_hi(arg_reg[0]),
		.off_lo(c_word ? arg_reg[1] : arg_reg[0]),
		.word(c_word),
		.sext(1'b0),
		.sum(ea_sum)
	);
	oad_offset_add u_br_add (
		.base(pc_reg),
		.off_hi(8'h00),
		.off_lo(last_arg),
		.word(1'b0),
		.sext(1'b1),
		.sum(tgt_sum)
	);
	always_comb begin
		case (c_mode)
			oad_pkg::page_zero_mode: ea_next = {`OAD_PZ_HI, arg_reg[0]};
			oad_pkg::full_address_mode: ea_next = {arg_reg[0], arg_reg[1]};
			oad_pkg::index_mode, oad_pkg::index_post_increment_mode: ea_next = hx_val;
			oad_pkg::index_byte_mode, oad_pkg::index_byte_post_increment_mode,
			oad_pkg::index_word_mode, oad_pkg::stack_offset_byte_mode,
			oad_pkg::stack_offset_word_mode: ea_next = ea_sum;
			default: ea_next = 16'h0000;
		endcase
	end
	assign lit_val = c_wide ? {arg_reg[0], arg_reg[1]} : {8'h00, arg_reg[0]};
	assign needs_read = !c_store && !c_ill && (c_mode != oad_pkg::no_operand_mode)
		&& (c_mode != oad_pkg::pc_offset_mode) && (c_mode != oad_pkg::literal_operand_mode);
	assign is_prefix = !page2_reg && (mem_rdata == `OAD_PREBYTE);

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			oad_pkg::st_idle: state_next = oad_pkg::st_idle;
			oad_pkg::st_fetch:
				if (mem_ack && !is_prefix)
					state_next = oad_pkg::st_args;
			oad_pkg::st_args:
				if (args_need == {1'b0, cnt_reg})
					state_next = oad_pkg::st_addr;
			oad_pkg::st_addr:
				state_next = needs_read ? oad_pkg::st_opnd : oad_pkg::st_issue;
			oad_pkg::st_opnd:
				if (mem_ack && (!wide_reg || opnd_cnt_reg))
					state_next = oad_pkg::st_issue;
			oad_pkg::st_issue:
				if (dec_ready)
					state_next = dec_branch ? oad_pkg::st_branch : oad_pkg::st_fetch;
			oad_pkg::st_branch:
				if (br_cond_valid)
					state_next = oad_pkg::st_fetch;
			default: state_next = oad_pkg::st_idle;
		endcase
		if (start)
			state_next = oad_pkg::st_fetch;
	end
	always_ff @(posedge clk_sys) begin
		if (srst)
			state_reg <= oad_pkg::st_idle;
		else
			state_reg <= state_next;
	end
	assign mem_req = (state_reg == oad_pkg::st_fetch) || (state_reg == oad_pkg::st_opnd)
		|| ((state_reg == oad_pkg::st_args) && ({1'b0, cnt_reg} < args_need));
	assign mem_addr = addr_reg;
	assign dec_valid = (state_reg == oad_pkg::st_issue);
	assign idx_inc = dec_valid && dec_ready && ((dec_dst == oad_pkg::dst_post_increment)
		|| (dec_mode == oad_pkg::index_post_increment_mode)
		|| (dec_mode == oad_pkg::index_byte_post_increment_mode));
	assign pc_out = pc_reg;

	// Program counter and bus address
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pc_reg <= `OAD_PC_RST;
			addr_reg <= `OAD_PC_RST;
		end else if (start) begin
			pc_reg <= start_pc;
			addr_reg <= start_pc;
		end else begin
			case (state_reg)
				oad_pkg::st_fetch, oad_pkg::st_args:
					if (mem_req && mem_ack) begin
						pc_reg <= 16'(pc_reg + 16'h0001);
						addr_reg <= 16'(pc_reg + 16'h0001);
					end
				oad_pkg::st_addr: addr_reg <= ea_next;
				oad_pkg::st_opnd:
					if (mem_ack)
						addr_reg <= 16'(addr_reg + 16'h0001);
				oad_pkg::st_issue:
					if (dec_ready)
						addr_reg <= pc_reg;
				oad_pkg::st_branch:
					if (br_cond_valid && br_cond) begin
						pc_reg <= target_reg;
						addr_reg <= target_reg;
					end
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// Opcode, prefix and argument bytes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			opcode_reg <= 8'h00;
			page2_reg <= 1'b0;
			cnt_reg <= 2'h0;
			for (int i = 0; i < 3; i++)
				arg_reg[i] <= 8'h00;
		end else if (start) begin
			page2_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else if (state_reg == oad_pkg::st_fetch && mem_ack) begin
			if (is_prefix)
				page2_reg <= 1'b1;
			else
				opcode_reg <= mem_rdata;
			cnt_reg <= 2'h0;
		end else if (state_reg == oad_pkg::st_args && mem_req && mem_ack) begin
			arg_reg[cnt_reg] <= mem_rdata;
			cnt_reg <= 2'(cnt_reg + 2'h1);
		end else if (state_reg == oad_pkg::st_issue && dec_ready) begin
			page2_reg <= 1'b0;
		end
	end

	// Decoded result and operand
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dec_page2 <= 1'b0;
			dec_opcode <= 8'h00;
			dec_mode <= oad_pkg::no_operand_mode;
			dec_dst <= oad_pkg::dst_none;
			dec_ea <= 16'h0000;
			dec_dst_ea <= 16'h0000;
			dec_operand <= 16'h0000;
			dec_len <= 3'h0;
			dec_cycles <= 4'h0;
			dec_branch <= 1'b0;
			dec_illegal <= 1'b0;
			wide_reg <= 1'b0;
			opnd_cnt_reg <= 1'b0;
			target_reg <= 16'h0000;
		end else if (state_reg == oad_pkg::st_addr) begin
			dec_page2 <= page2_reg;
			dec_opcode <= opcode_reg;
			dec_mode <= c_mode;
			dec_dst <= c_dst;
			dec_ea <= ea_next;
			dec_dst_ea <= (c_dst == oad_pkg::dst_page_zero) ? {`OAD_PZ_HI, last_arg} : hx_val;
			dec_operand <= (c_mode == oad_pkg::literal_operand_mode) ? lit_val : 16'h0000;
			dec_len <= c_len;
			dec_cycles <= c_cyc;
			dec_branch <= c_br;
			dec_illegal <= c_ill;
			wide_reg <= c_wide;
			opnd_cnt_reg <= 1'b0;
			target_reg <= tgt_sum;
		end else if (state_reg == oad_pkg::st_opnd && mem_ack) begin
			dec_operand <= {dec_operand[7:0], mem_rdata};
			opnd_cnt_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst)
			pc_valid <= 1'b0;
		else
			pc_valid <= !start && (state_reg == oad_pkg::st_branch) && br_cond_valid;
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_prefix_seen;
		state_reg == oad_pkg::st_fetch && mem_ack && is_prefix && !start;
	endsequence
	sequence s_resolve(logic taken);
		state_reg == oad_pkg::st_branch && br_cond_valid && br_cond == taken && !start;
	endsequence
	AST_ONE_SPACE: assert property ((state_reg == oad_pkg::st_addr && needs_read && !start)
		|=> mem_req && mem_addr == $past(ea_next)) else $error("Operand read address wrong");
	AST_MOVE_DST: assert property ((state_reg == oad_pkg::st_addr && c_dst == oad_pkg::dst_page_zero)
		|=> dec_dst_ea == {`OAD_PZ_HI, $past(last_arg)} && dec_ea == $past(ea_next))
		else $error("Move destination wrong");
	AST_BR_HOLD: assert property (s_resolve(1'b0) |=> pc_valid && pc_out == $past(pc_reg))
		else $error("Untaken branch moved pc");
	AST_NO_READ: assert property ((state_reg == oad_pkg::st_addr && !start
		&& c_mode == oad_pkg::no_operand_mode) |=> state_reg == oad_pkg::st_issue && !mem_req)
		else $error("No-operand mode read memory");
	AST_REL_BYTE: assert property ((dec_valid && dec_branch)
		|-> target_reg == 16'(pc_reg + {{8{last_arg[7]}}, last_arg}))
		else $error("Branch target wrong");
	AST_BR_TAKEN: assert property (s_resolve(1'b1)
		|=> pc_valid && pc_out == $past(target_reg) && mem_addr == pc_out)
		else $error("Taken branch not followed");
	AST_LIT_NOREAD: assert property ((state_reg == oad_pkg::st_addr && !start
		&& c_mode == oad_pkg::literal_operand_mode) |=> dec_valid && dec_operand == $past(lit_val))
		else $error("Literal operand wrong");
	AST_LIT16: assert property ((dec_valid && dec_mode == oad_pkg::literal_operand_mode
		&& wide_reg) |-> dec_operand == {arg_reg[0], arg_reg[1]}) else $error("Literal byte order");
	AST_PAGE_ZERO: assert property ((dec_valid && dec_mode == oad_pkg::page_zero_mode)
		|-> dec_ea == {`OAD_PZ_HI, arg_reg[0]}) else $error("Page-zero address wrong");
	AST_PREFIX: assert property (s_prefix_seen
		|=> page2_reg && state_reg == oad_pkg::st_fetch) else $error("Prefix not taken");
	AST_NEG_P2: assert property ((dec_valid && dec_page2 && dec_opcode == {`OAD_COL_RMW, 4'h0})
		|-> dec_len == `OAD_LEN_THREE && dec_cycles == `OAD_CYC_RMW
		&& dec_mode == oad_pkg::stack_offset_byte_mode) else $error("Prefixed negate entry wrong");
	AST_POST_INC: assert property ((dec_valid && dec_ready
		&& dec_mode == oad_pkg::index_post_increment_mode) |-> idx_inc ##1 !idx_inc)
		else $error("Post increment missing");
	AST_SP_WORD: assert property ((state_reg == oad_pkg::st_addr
		&& c_mode == oad_pkg::stack_offset_word_mode)
		|=> dec_ea == 16'($past(sp_val) + {$past(arg_reg[0]), $past(arg_reg[1])}))
		else $error("Stack word address wrong");
endmodule : oad_decoder
`default_nettype wire

// >>> tb/oad_mem_model.sv
// Address space model answering byte reads after a set number of wait cycles
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Read port
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	// Wait cycles before each answer
	input wire logic [3:0] lat
);
	logic [7:0] mem [0:65535];
	logic [15:0] log_q [$];
	logic [3:0] wait_reg;
	logic [7:0] last_reg;
	assign mem_ack = mem_req && (wait_reg >= lat);
	// Off-answer data is the inverse of the last byte handed out
	assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_reg;
	always @(posedge clk_sys) begin
		if (srst || !mem_req || mem_ack) begin
			wait_reg <= 4'h0;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
		if (srst) begin
			last_reg <= 8'h00;
		end else if (mem_req && mem_ack) begin
			last_reg <= mem[mem_addr];
			log_q.push_back(mem_addr);
		end
	end
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end
endmodule : oad_mem_model
`default_nettype wire

// >>> tb/oad_decoder_tb.sv
// Self-checking bench for the operand address decoder
`timescale 1ns/1ps
`default_nettype none
module oad_decoder_tb;
	logic clk_sys, srst, start, mem_req, mem_ack, dec_valid, dec_ready, dec_page2;
	logic [15:0] start_pc, sp_val, hx_val, mem_addr, dec_ea, dec_dst_ea, dec_operand, pc_out;
	logic [7:0] map_opcode, mem_rdata, dec_opcode;
	oad_pkg::oad_mode_t map_mode, dec_mode;
	oad_pkg::oad_dst_t map_dst, dec_dst;
	logic map_branch, map_wide, map_store, map_illegal, dec_branch, dec_illegal, idx_inc;
	logic [2:0] map_len, dec_len;
	logic [3:0] map_cycles, dec_cycles, lat;
	logic br_cond_valid, br_cond, pc_valid;
	int bad_count = 0;
	int total_checks = 0;
	oad_decoder u_oad_decoder (.clk_sys(clk_sys), .srst(srst), .start(start),
		.start_pc(start_pc), .sp_val(sp_val), .hx_val(hx_val), .map_opcode(map_opcode),
		.map_mode(map_mode), .map_dst(map_dst), .map_branch(map_branch), .map_wide(map_wide),
		.map_store(map_store), .map_illegal(map_illegal), .map_len(map_len),
		.map_cycles(map_cycles), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.dec_page2(dec_page2), .dec_opcode(dec_opcode), .dec_mode(dec_mode),
		.dec_dst(dec_dst), .dec_ea(dec_ea), .dec_dst_ea(dec_dst_ea),
		.dec_operand(dec_operand), .dec_len(dec_len), .dec_cycles(dec_cycles),
		.dec_branch(dec_branch), .dec_illegal(dec_illegal), .idx_inc(idx_inc),
		.br_cond_valid(br_cond_valid), .br_cond(br_cond), .pc_valid(pc_valid),
		.pc_out(pc_out));
	oad_mem_model u_oad_mem_model (.clk_sys(clk_sys), .srst(srst), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic summarize();
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic check_log(input logic [15:0] exp[$]);
		check("reads", 16'(u_oad_mem_model.log_q.size()), 16'(exp.size()));
		foreach (exp[i]) check("read_addr", u_oad_mem_model.log_q[i], exp[i]);
	endtask : check_log
	task automatic set_map(input oad_pkg::oad_mode_t m, input oad_pkg::oad_dst_t d,
		input logic br, input logic wide, input logic [2:0] len, input logic [3:0] cyc);
		map_mode = m;
		map_dst = d;
		map_branch = br;
		map_wide = wide;
		map_len = len;
		map_cycles = cyc;
	endtask : set_map
	// Load code, restart at pc, wait for the decoded instruction
	task automatic issue(input logic [15:0] pc, input logic [7:0] code[$]);
		int n;
		foreach (code[i]) u_oad_mem_model.mem[pc + 16'(i)] = code[i];
		start_pc = pc;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		u_oad_mem_model.log_q.delete();
		n = 0;
		while (dec_valid !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		check("dec_valid", 16'(dec_valid), 16'h0001);
	endtask : issue
	task automatic accept(input logic exp_inc);
		dec_ready = 1'b1;
		#1;
		check("idx_inc", 16'(idx_inc), 16'(exp_inc));
		@(negedge clk_sys);
		dec_ready = 1'b0;
	endtask : accept
	task automatic t_page_zero();
		set_map(oad_pkg::page_zero_mode, oad_pkg::dst_none, 1'b0, 1'b0, 3'h2, 4'h3);
		u_oad_mem_model.mem[16'h00FF] = 8'h5A;
		issue(16'h1000, '{8'hB6, 8'hFF});
		check("ea", dec_ea, 16'h00FF);
		check("operand", dec_operand, 16'h005A);
		check("len", 16'(dec_len), 16'h0002);
		check("map_opcode", 16'(map_opcode), 16'h00B6);
		check("illegal", 16'(dec_illegal), 16'h0000);
		check_log('{16'h1000, 16'h1001, 16'h00FF});
		accept(1'b0);
	endtask : t_page_zero
	task automatic t_no_operand();
		set_map(oad_pkg::no_operand_mode, oad_pkg::dst_none, 1'b0, 1'b0, 3'h1, 4'h1);
		issue(16'h1100, '{8'h4C});
		check("mode", 16'(dec_mode), 16'(oad_pkg::no_operand_mode));
		check_log('{16'h1100});
		accept(1'b0);
	endtask : t_no_operand
	task automatic t_literal();
		set_map(oad_pkg::literal_operand_mode, oad_pkg::dst_none, 1'b0, 1'b1, 3'h3, 4'h3);
		issue(16'h1200, '{8'h45, 8'h12, 8'h34});
		check("wide literal", dec_operand, 16'h1234);
		check_log('{16'h1200, 16'h1201, 16'h1202});
		accept(1'b0);
		set_map(oad_pkg::literal_operand_mode, oad_pkg::dst_none, 1'b0, 1'b0, 3'h2, 4'h2);
		issue(16'h1280, '{8'hA6, 8'h9C});
		check("byte literal", dec_operand, 16'h009C);
		accept(1'b0);
	endtask : t_literal
	// Prefixed stack forms; the primary map answer is deliberately wrong
	task automatic t_page2(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo,
		input oad_pkg::oad_mode_t m, input logic [2:0] len, input logic [3:0] cyc);
		logic [15:0] ea;
		logic [15:0] q[$];
		ea = sp_val + ((len == 3'h4) ? {hi, lo} : {8'h00, lo});
		u_oad_mem_model.mem[ea] = 8'h77;
		set_map(oad_pkg::literal_operand_mode, oad_pkg::dst_none, 1'b0, 1'b0, 3'h2, 4'h1);
		if (len == 3'h4) issue(16'h1600, '{8'h9E, op, hi, lo});
		else issue(16'h1600, '{8'h9E, op, lo});
		check("page2", 16'(dec_page2), 16'h0001);
		check("opcode", 16'(dec_opcode), 16'(op));
		check("mode", 16'(dec_mode), 16'(m));
		check("len", 16'(dec_len), 16'(len));
		check("cycles", 16'(dec_cycles), 16'(cyc));
		check("ea", dec_ea, ea);
		check("operand", dec_operand, 16'h0077);
		for (int i = 0; i < 32'(len); i++) q.push_back(16'h1600 + 16'(i));
		q.push_back(ea);
		check_log(q);
		accept(1'b0);
	endtask : t_page2
	// Prefixed gap entry and prefixed store: neither reads an operand
	task automatic t_page2_skip();
		issue(16'h1700, '{8'h9E, 8'h62});
		check("illegal", 16'(dec_illegal), 16'h0001);
		check("cycles", 16'(dec_cycles), 16'h0001);
		check_log('{16'h1700, 16'h1701});
		accept(1'b0);
		issue(16'h1780, '{8'h9E, 8'hE7, 8'h10});
		check("illegal", 16'(dec_illegal), 16'h0000);
		check("store ea", dec_ea, 16'h0210);
		check_log('{16'h1780, 16'h1781, 16'h1782});
		accept(1'b0);
	endtask : t_page2_skip
	task automatic t_move();
		set_map(oad_pkg::page_zero_mode, oad_pkg::dst_page_zero, 1'b0, 1'b0, 3'h3, 4'h5);
		u_oad_mem_model.mem[16'h0010] = 8'h3C;
		issue(16'h1300, '{8'h4E, 8'h10, 8'h20});
		check("src ea", dec_ea, 16'h0010);
		check("dst ea", dec_dst_ea, 16'h0020);
		check("operand", dec_operand, 16'h003C);
		accept(1'b0);
		set_map(oad_pkg::index_post_increment_mode, oad_pkg::dst_page_zero, 1'b0, 1'b0,
			3'h2, 4'h5);
		u_oad_mem_model.mem[16'h0050] = 8'h61;
		issue(16'h1400, '{8'h7E, 8'h30});
		check("src ea", dec_ea, 16'h0050);
		check("dst ea", dec_dst_ea, 16'h0030);
		check("operand", dec_operand, 16'h0061);
		accept(1'b1);
	endtask : t_move
	task automatic t_branch(input logic [15:0] pc, input logic [7:0] code[$],
		input oad_pkg::oad_mode_t m, input logic cond, input logic [15:0] target);
		int n;
		set_map(m, oad_pkg::dst_none, 1'b1, 1'b0, 3'(code.size()), 4'h4);
		issue(pc, code);
		check("branch", 16'(dec_branch), 16'h0001);
		accept(1'b0);
		br_cond_valid = 1'b1;
		br_cond = cond;
		@(negedge clk_sys);
		br_cond_valid = 1'b0;
		n = 0;
		while (pc_valid !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		check("pc_valid", 16'(pc_valid), 16'h0001);
		check("pc_out", pc_out, target);
		u_oad_mem_model.log_q.delete();
		repeat (8) @(negedge clk_sys);
		check("refetch", u_oad_mem_model.log_q[0], target);
	endtask : t_branch
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		summarize();
	end
	initial begin
		{srst, start, dec_ready, br_cond_valid, br_cond, map_store, map_illegal} = 7'h40;
		{start_pc, sp_val, hx_val, lat} = {16'h0000, 16'h0200, 16'h0050, 4'h0};
		set_map(oad_pkg::no_operand_mode, oad_pkg::dst_none, 1'b0, 1'b0, 3'h1, 4'h1);
		repeat (16) @(negedge clk_sys);
		check("reset req", 16'(mem_req), 16'h0000);
		check("reset valid", 16'(dec_valid), 16'h0000);
		srst = 1'b0;
		t_page_zero();
		t_no_operand();
		t_literal();
		t_page2(8'h60, 8'h00, 8'h05, oad_pkg::stack_offset_byte_mode, 3'h3, 4'h6);
		t_page2(8'hD6, 8'h01, 8'h02, oad_pkg::stack_offset_word_mode, 3'h4, 4'h5);
		t_page2(8'hEB, 8'h00, 8'h7F, oad_pkg::stack_offset_byte_mode, 3'h3, 4'h4);
		t_page2_skip();
		t_move();
		lat = 4'h2;
		u_oad_mem_model.mem[16'h0030] = 8'h11;
		t_branch(16'h1500, '{8'h31, 8'h30, 8'h05}, oad_pkg::page_zero_mode, 1'b1,
			16'h1508);
		t_branch(16'h2000, '{8'h27, 8'hFC}, oad_pkg::pc_offset_mode, 1'b1, 16'h1FFE);
		t_branch(16'h2100, '{8'h27, 8'hFC}, oad_pkg::pc_offset_mode, 1'b0, 16'h2102);
		summarize();
	end
endmodule : oad_decoder_tb
`default_nettype wire
